// ==== src/rsc_params.svh ====
// Constants for the reset source controller
// Assumes a 125 MHz pclk; included by the package and the modules
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_CLK_NS        8
`define RSC_STRETCH_NS    4096
`define RSC_STRETCH_CYC   (`RSC_STRETCH_NS / `RSC_CLK_NS)
`define RSC_DROOP_MIN_NS  2000
`define RSC_DROOP_MIN_CYC ((`RSC_DROOP_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_PIN_MIN_NS    2500
`define RSC_PIN_MIN_CYC   ((`RSC_PIN_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_ADDR_W        12
`define RSC_FLAGS_OFS     12'h000
`define RSC_POR_BIT       0
`define RSC_PIN_BIT       1
`define RSC_DROOP_BIT     2
`define RSC_DOG_BIT       3
`define RSC_FLAGS_W       4
`define RSC_FLAGS_RST     4'h1
`define RSC_LVL_OFF       3'h7
`define RSC_LVL_1V8       3'h6
`define RSC_LVL_2V7       3'h5
`define RSC_LVL_4V3       3'h4
`define RSC_CNT_W         24
`define RSC_FCNT_W        16
`define RSC_MAX_SHIFT     4
`endif

// ==== src/rsc_pkg.sv ====
// Types shared by the reset source controller modules
// Assumes rsc_params.svh sits on the include path
`include "rsc_params.svh"
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_HOLD  = 3'h1,
        RSC_COUNT = 3'h2,
        RSC_DONE  = 3'h4
    } rsc_phase_t;

    typedef struct packed {
        logic                    dis1;
        logic                    dis2;
        logic [2:0]              lvl1;
        logic [2:0]              lvl2;
        logic [1:0]              sut1;
        logic [1:0]              sut2;
        logic [3:0]              ck1;
        logic [3:0]              ck2;
        logic                    por1;
        logic                    por2;
        logic                    dog_prev;
        logic                    dog_pulse;
        rsc_phase_t              ph;
        logic [`RSC_CNT_W-1:0]   cnt;
        logic [`RSC_FLAGS_W-1:0] flags;
        logic [7:0]              rdata;
    } rsc_top_t;

    typedef struct packed {
        logic                   s1;
        logic                   s2;
        logic [`RSC_FCNT_W-1:0] cnt;
        logic                   held;
    } rsc_filt_t;
endpackage : rsc_pkg

// ==== src/rsc_pulse_filter.sv ====
// Synchronises an asynchronous active-high level and passes it on only
// after it has stood for more than MIN_CYC cycles; release follows at once.
// Assumes the level comes from outside the pclk domain.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_pulse_filter
    import rsc_pkg::*;
#(
    parameter int MIN_CYC = 1
) (
    input  wire logic pclk,     // System clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic raw,      // Asynchronous active level
    output logic      held      // Filtered, synchronised level
);
    localparam logic [`RSC_FCNT_W-1:0] LIM = `RSC_FCNT_W'(MIN_CYC);
    rsc_filt_t s;
    rsc_filt_t next_s;

    if (MIN_CYC < 1 || MIN_CYC >= (1 << `RSC_FCNT_W)) begin : g_chk
        $error("rsc_pulse_filter: MIN_CYC out of range");
    end

    always_comb begin
        next_s    = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
        // Short dips never reach the counter limit, so they are dropped
        if (!s.s2) begin
            next_s.cnt  = '0;
            next_s.held = 1'b0;
        end else if (s.cnt != LIM) begin
            next_s.cnt = s.cnt + 1'b1;
        end else begin
            next_s.held = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign held = s.held;

    a_filter_width: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(held) |-> $past(s.s2, 1) && $past(s.cnt, 1) == LIM)
        else $error("Filtered level rose before minimum width");
endmodule : rsc_pulse_filter

// ==== src/rsc_top.sv ====
// Reset source controller: merges power-up, pin, supply droop and
// watchdog sources into one stretched core reset, keeps cause flags
// and serves them over APB. Assumes analog detectors drive levels,
// fuse inputs are static, and the watchdog strobe is on pclk.
//
// Summary of operation
// - Core reset stays asserted while the power-up detector reports low supply.
// - Supply rising past threshold starts the stretch counter before release.
// - Supply falling below power-up level reasserts reset at once.
// - Pin held low resets the core even without a clock.
// - After a pin low longer than the pin filter width returns high, the full stretch period runs.
// - A fuse input disables the pin as a reset source.
// - Three-bit code picks droop level; 111 and reserved codes disable it.
// - Enabled droop asserts reset after the filter and sync delay, releases after the stretch period.
// - Droop dips shorter than the minimum pulse width are ignored.
// - Watchdog timeout makes an internal reset pulse of exactly one cycle.
// - Stretch counting starts when that watchdog pulse falls.
// - Status bits 7 to 4 always read zero.
// - Bit 3 set by watchdog reset; cleared by power-up or zero write.
// - Bit 2 set by droop reset; cleared by power-up or zero write.
// - Bit 1 set by pin reset; cleared by power-up or zero write.
// - Bit 0 set by power-up reset; cleared only by zero write.
// - Stretch period comes from start-up time and clock-source fuses.
// - Port reset output asserts asynchronously for power-up and pin; droop and watchdog assert it on pclk.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_top
    import rsc_pkg::*;
#(
    parameter int STRETCH_BASE = `RSC_STRETCH_CYC,
    parameter int DROOP_MIN    = `RSC_DROOP_MIN_CYC,
    parameter int PIN_MIN      = `RSC_PIN_MIN_CYC
) (
    input  wire logic                  pclk,                   // System clock
    input  wire logic                  presetn,                // Async reset, low
    input  wire logic                  psel,                   // APB select
    input  wire logic                  penable,                // APB enable
    input  wire logic                  pwrite,                 // APB write
    input  wire logic [`RSC_ADDR_W-1:0] paddr,                 // APB address
    input  wire logic [31:0]           pwdata,                 // APB write data
    output logic [31:0]                prdata,                 // APB read data
    output logic                       pready,                 // APB ready
    output logic                       pslverr,                // APB error
    input  wire logic                  powerup_low,            // Supply below threshold
    input  wire logic                  ext_reset_n,            // Reset pin, low
    input  wire logic                  supply_droop_detect,    // Supply below droop level
    input  wire logic                  dog_timeout,            // Watchdog expiry strobe
    input  wire logic                  pin_reset_disable_fuse, // Pin source off
    input  wire logic [2:0]            droop_level_code,       // Droop level fuses
    input  wire logic [1:0]            startup_time_select,    // Start-up fuses
    input  wire logic [3:0]            clock_source_select,    // Clock fuses
    output logic                       droop_enable,           // Droop comparator on
    output logic [2:0]                 droop_level_sel,        // Droop level to comparator
    output logic                       core_reset_n,           // Core and port reset
    output logic [`RSC_FLAGS_W-1:0]    reset_cause_flags       // Cause flags
);
    rsc_top_t s;
    rsc_top_t next_s;

    if (STRETCH_BASE < 1 ||
        STRETCH_BASE >= (1 << (`RSC_CNT_W - `RSC_MAX_SHIFT))) begin : g_chk_st
        $error("rsc_top: STRETCH_BASE out of range");
    end

    logic                    pin_raw;
    logic                    pin_held;
    logic                    droop_held;
    logic                    droop_on;
    logic                    src_any;
    logic                    async_src;
    logic [2:0]              shift;
    logic [`RSC_CNT_W-1:0]   stretch_len;
    logic                    hit;
    logic                    wr;
    logic [`RSC_FLAGS_W-1:0] set_vec;

    assign pin_raw = !ext_reset_n && !s.dis2;

    // Pin flag wants a qualified pulse; the async path below does not wait
    rsc_pulse_filter #(
        .MIN_CYC (PIN_MIN)
    ) u_pin_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (pin_raw),
        .held    (pin_held)
    );

    rsc_pulse_filter #(
        .MIN_CYC (DROOP_MIN)
    ) u_droop_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (supply_droop_detect),
        .held    (droop_held)
    );

    always_comb begin
        droop_on = 1'b0;
        if (s.lvl2 == `RSC_LVL_1V8) begin
            droop_on = 1'b1;
        end else if (s.lvl2 == `RSC_LVL_2V7) begin
            droop_on = 1'b1;
        end else if (s.lvl2 == `RSC_LVL_4V3) begin
            droop_on = 1'b1;
        end
    end

    assign src_any = s.por2 || pin_held || (droop_held && droop_on) ||
                     s.dog_pulse;

    assign shift = {1'b0, s.sut2} + {2'b00, s.ck2[3]};
    assign stretch_len = `RSC_CNT_W'(STRETCH_BASE) << shift;

    // async assertion path
    // Raw levels are used on purpose: there may be no clock to sync them
    assign async_src = powerup_low || pin_raw;
    assign core_reset_n = !(async_src || src_any || s.ph != RSC_DONE);

    assign hit = (paddr == `RSC_FLAGS_OFS);
    assign wr  = psel && penable && pwrite && hit;

    always_comb begin
        set_vec = '0;
        set_vec[`RSC_PIN_BIT] = pin_held;
        set_vec[`RSC_DROOP_BIT] = droop_held && droop_on;
        set_vec[`RSC_DOG_BIT] = s.dog_pulse;
    end

    always_comb begin
        next_s      = s;
        next_s.dis1 = pin_reset_disable_fuse;
        next_s.dis2 = s.dis1;
        next_s.lvl1 = droop_level_code;
        next_s.lvl2 = s.lvl1;
        next_s.sut1 = startup_time_select;
        next_s.sut2 = s.sut1;
        next_s.ck1  = clock_source_select;
        next_s.ck2  = s.ck1;
        next_s.por1 = powerup_low;
        next_s.por2 = s.por1;

        next_s.dog_prev  = dog_timeout;
        next_s.dog_pulse = dog_timeout && !s.dog_prev;

        case (s.ph)
            RSC_HOLD: begin
                next_s.cnt = '0;
                if (!src_any) begin
                    next_s.ph = RSC_COUNT;
                end
            end
            RSC_COUNT: begin
                if (src_any) begin
                    next_s.ph  = RSC_HOLD;
                    next_s.cnt = '0;
                end else if (s.cnt == stretch_len - 1'b1) begin
                    next_s.ph = RSC_DONE;
                end else begin
                    next_s.cnt = s.cnt + 1'b1;
                end
            end
            RSC_DONE: begin
                if (src_any) begin
                    next_s.ph  = RSC_HOLD;
                    next_s.cnt = '0;
                end
            end
            default: begin
                next_s.ph  = RSC_HOLD;
                next_s.cnt = '0;
            end
        endcase

        if (s.por2) begin
            next_s.flags = `RSC_FLAGS_RST;
        end else begin
            // A set in the same cycle as a zero write survives it
            if (wr) begin
                next_s.flags = s.flags & pwdata[`RSC_FLAGS_W-1:0];
            end
            next_s.flags = next_s.flags | set_vec;
        end

        // Read data captured in the setup phase, shown in the access phase
        if (psel && !penable && !pwrite) begin
            if (hit) begin
                next_s.rdata = {4'h0, s.flags};
            end else begin
                next_s.rdata = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.ph    <= RSC_HOLD;
            s.lvl1  <= `RSC_LVL_OFF;
            s.lvl2  <= `RSC_LVL_OFF;
            s.flags <= `RSC_FLAGS_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata            = {24'h000000, s.rdata};
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && !hit;
    assign droop_enable      = droop_on;
    assign droop_level_sel   = s.lvl2;
    assign reset_cause_flags = s.flags;

    a_por_holds: assert property (@(posedge pclk) disable iff (!presetn)
        s.por2 |-> !core_reset_n ##1 !core_reset_n)
        else $error("Reset released while supply low");

    a_por_stretch: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(core_reset_n) |->
            $past(s.ph, 1) == RSC_COUNT && $past(s.cnt, 1) == stretch_len - 1'b1)
        else $error("Reset released before full stretch");

    a_por_instant: assert property (@(posedge pclk) disable iff (!presetn)
        powerup_low |-> !core_reset_n)
        else $error("Supply low without reset");

    a_pin_async: assert property (@(posedge pclk) disable iff (!presetn)
        pin_raw |-> !core_reset_n)
        else $error("Pin low without reset");

    a_pin_restart: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pin_held) && !src_any |-> s.ph == RSC_HOLD ##1 s.ph == RSC_COUNT)
        else $error("Pin release skipped counting");

    a_fuse_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        s.dis2 |-> !pin_raw)
        else $error("Disabled pin still acts");

    a_droop_off: assert property (@(posedge pclk) disable iff (!presetn)
        s.lvl2 == `RSC_LVL_OFF |-> !droop_enable)
        else $error("Droop enabled by off code");

    a_droop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        droop_held && droop_on |-> !core_reset_n ##1 s.ph == RSC_HOLD)
        else $error("Droop did not hold reset");

    a_dog_single: assert property (@(posedge pclk) disable iff (!presetn)
        s.dog_pulse |=> !s.dog_pulse)
        else $error("Watchdog pulse longer than one cycle");

    a_dog_count: assert property (@(posedge pclk) disable iff (!presetn)
        s.dog_pulse && !s.por2 |=> s.flags[`RSC_DOG_BIT] && s.ph == RSC_HOLD)
        else $error("Watchdog reset not recorded");

    a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:`RSC_FLAGS_W] == '0)
        else $error("Reserved status bits not zero");

    a_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
        s.por2 |=> s.flags == `RSC_FLAGS_RST)
        else $error("Power-up did not set only its flag");

    a_count_restart: assert property (@(posedge pclk) disable iff (!presetn)
        s.ph == RSC_COUNT && src_any |=> s.ph == RSC_HOLD && s.cnt == '0)
        else $error("Counter did not restart");

    c_full_release: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(core_reset_n));
    c_dog_reset: cover property (@(posedge pclk) disable iff (!presetn)
        s.dog_pulse ##1 s.ph == RSC_HOLD ##1 s.ph == RSC_COUNT);
    c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn)
        wr && s.flags != '0 ##1 s.flags == '0);
endmodule : rsc_top

// ==== tb/reset_source_controller_bench.sv ====
// Self-checking bench for the reset source controller
// Assumes short stretch and filter parameters; flags served at offset 0
`timescale 1ns/1ps
`include "rsc_params.svh"
module reset_source_controller_bench
    import rsc_pkg::*;
;
    localparam int SB = 4;
    localparam int FM = 2;
    logic        pclk = 1'b0, presetn = 1'b0, clk_run = 1'b1;
    logic        psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, wd, r;
    logic        pready, pslverr, er, powerup_low, ext_reset_n, supply_droop_detect;
    logic        dog_timeout, pin_reset_disable_fuse, droop_enable;
    logic [2:0]  droop_level_code, droop_level_sel;
    logic [1:0]  startup_time_select;
    logic [3:0]  clock_source_select, reset_cause_flags, exp;
    logic        core_reset_n;
    int          err_count = 0, check_count = 0, seed = 50, n, d0, d1, d2;

    always #4 pclk = clk_run ? ~pclk : pclk;

    rsc_top #(.STRETCH_BASE(SB), .DROOP_MIN(FM), .PIN_MIN(FM)) rsc_top_i (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .powerup_low,
        .ext_reset_n, .supply_droop_detect, .dog_timeout, .pin_reset_disable_fuse,
        .droop_level_code, .startup_time_select, .clock_source_select, .droop_enable,
        .droop_level_sel, .core_reset_n, .reset_cause_flags);
    rsc_far_side rsc_far_side_i (.pclk, .powerup_low, .ext_reset_n, .supply_droop_detect);

    function automatic int stretch_len(input int s, input int c3);
        return SB << (s + c3);
    endfunction : stretch_len

    function automatic logic droop_on(input logic [2:0] c);
        return c inside {3'h4, 3'h5, 3'h6};
    endfunction : droop_on

    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask : chk

    task finish_test;
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [3:0] e);
        apb(1'b0, `RSC_FLAGS_OFS, 32'h0);
        chk(r, {28'h0, e});
    endtask : rd_chk

    task wait_release(output int m);
        int k;
        k = 0;
        m = 0;
        while (core_reset_n !== 1'b0 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        while (core_reset_n !== 1'b1 && m < 2000) begin
            @(posedge pclk);
            m++;
        end
    endtask : wait_release

    task dog(input logic [1:0] s, input logic [3:0] c, output int m);
        startup_time_select <= s;
        clock_source_select <= c;
        repeat (4) @(posedge pclk);
        dog_timeout <= 1'b1;
        @(posedge pclk);
        dog_timeout <= 1'b0;
        wait_release(m);
    endtask : dog

    initial begin
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        dog_timeout            <= 1'b0;
        pin_reset_disable_fuse <= 1'b0;
        droop_level_code       <= 3'h7;
        startup_time_select    <= 2'h0;
        clock_source_select    <= 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wait_release(n);
        chk(32'(n >= stretch_len(0, 0)), 32'h1);
        rd_chk(4'h1);
        apb(1'b1, 12'h004, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk({er, r[30:0]}, 32'h80000000);
        wd = $random(seed);
        wd[0] = 1'b0;
        apb(1'b1, `RSC_FLAGS_OFS, wd);
        exp = 4'h1 & wd[3:0];
        rd_chk(exp);
        $display("test registers done");
        dog(2'h0, {1'b0, 3'($random(seed))}, d0);
        dog(2'h1, {1'b0, 3'($random(seed))}, d1);
        dog(2'h1, 4'h8, d2);
        chk(d1 - d0, stretch_len(1, 0) - stretch_len(0, 0));
        chk(d2 - d0, stretch_len(1, 1) - stretch_len(0, 0));
        exp = exp | 4'h8;
        rd_chk(exp);
        wd = $random(seed) & 32'hfffffff7;
        apb(1'b1, `RSC_FLAGS_OFS, wd);
        exp = exp & wd[3:0];
        rd_chk(exp);
        $display("test watchdog done");
        // pin acts with the clock stopped
        @(negedge pclk);
        clk_run = 1'b0;
        rsc_far_side_i.pin_now(1'b0);
        #20 chk({31'h0, core_reset_n}, 32'h0);
        clk_run = 1'b1;
        // Unsigned draw: a negative remainder would cut the pin low below the filter width
        repeat (FM + 3 + {$random(seed)} % 4) @(posedge pclk);
        rsc_far_side_i.set_pin(1'b1);
        wait_release(n);
        chk(32'(n >= SB), 32'h1);
        exp = exp | 4'h2;
        rd_chk(exp);
        pin_reset_disable_fuse <= 1'b1;
        repeat (4) @(posedge pclk);
        rsc_far_side_i.set_pin(1'b0);
        repeat (FM + 8) @(posedge pclk);
        chk({31'h0, core_reset_n}, 32'h1);
        rsc_far_side_i.set_pin(1'b1);
        pin_reset_disable_fuse <= 1'b0;
        rd_chk(exp);
        $display("test pin done");
        for (int c = 0; c < 8; c++) begin
            droop_level_code <= 3'(c);
            repeat (4) @(posedge pclk);
            chk({31'h0, droop_enable}, {31'h0, droop_on(3'(c))});
            chk({29'h0, droop_level_sel}, c);
            rsc_far_side_i.set_droop(1'b1);
            repeat (FM + 5) @(posedge pclk);
            chk({31'h0, core_reset_n}, {31'h0, !droop_on(3'(c))});
            rsc_far_side_i.set_droop(1'b0);
            wait_release(n);
            if (droop_on(3'(c))) exp = exp | 4'h4;
            rd_chk(exp);
        end
        droop_level_code <= 3'h6;
        repeat (4) @(posedge pclk);
        rsc_far_side_i.set_droop(1'b1);
        rsc_far_side_i.set_droop(1'b0);
        repeat (FM + 6) @(posedge pclk);
        chk({31'h0, core_reset_n}, 32'h1);
        $display("test droop done");
        // power-up overrides and clears the other flags
        rsc_far_side_i.set_power(1'b1);
        #1 chk({31'h0, core_reset_n}, 32'h0);
        repeat (SB + 6) @(posedge pclk);
        chk({31'h0, core_reset_n}, 32'h0);
        rsc_far_side_i.set_power(1'b0);
        wait_release(n);
        chk(32'(n >= SB), 32'h1);
        rd_chk(4'h1);
        $display("test power-up done");
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        finish_test;
    end
endmodule : reset_source_controller_bench

// ==== tb/rsc_far_side.sv ====
// Far-side model: power-up detector, droop comparator and reset pin driver
// Assumes the bench calls its tasks; set_power, set_droop and set_pin change levels just after pclk rises
`timescale 1ns/1ps
module rsc_far_side (
    input  wire logic pclk,                // System clock
    output logic      powerup_low,         // Supply below power-up level
    output logic      ext_reset_n,         // Reset pin, pulled up when idle
    output logic      supply_droop_detect  // Supply below droop level
);
    initial begin
        powerup_low = 1'b0;
        ext_reset_n = 1'b1;
        supply_droop_detect = 1'b0;
    end

    task set_power(input logic v);
        @(posedge pclk);
        powerup_low <= v;
    endtask : set_power

    task set_droop(input logic v);
        @(posedge pclk);
        supply_droop_detect <= v;
    endtask : set_droop

    // A released pin returns to its pull-up level, never holds a stale low
    task set_pin(input logic v);
        @(posedge pclk);
        ext_reset_n <= v;
    endtask : set_pin

    // Used while the clock is stopped, so no edge is waited for
    task pin_now(input logic v);
        ext_reset_n = v;
    endtask : pin_now
endmodule : rsc_far_side
